// *** dv/mmr_host_model.sv ***
`timescale 1ns/1ns
// host-side reader that fetches 32-bit monitor values word by word
module mmr_host_model
    import mmr_pkg::*;
(
    input  wire logic              clk,
    output logic [ADDR_W-1:0]      rd_addr,
    output logic                   rd_en,
    input  wire logic [WORD_W-1:0] rd_data,
    input  wire logic              rd_valid,
    input  wire logic              rd_err
);
    initial
    begin
        rd_en   = 1'b0;
        rd_addr = 16'h0000;
    end

    // request spans one rising edge; answer sampled half a cycle later
    task automatic read_word(input logic [15:0] a, output logic [15:0] d,
                             output logic e, output logic v);
        @(negedge clk);
        rd_en   = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en   = 1'b0;
        rd_addr = ~a;
        v = rd_valid;
        d = rd_data;
        e = rd_err;
    endtask : read_word

    // no snapshot in the bank, so a moving value may tear between halves
    task automatic read_value(input logic [15:0] a, output logic [31:0] val,
                              output logic [1:0] err, output logic [1:0] ok);
        read_word(a, val[31:16], err[1], ok[1]);
        read_word(a + 16'h0001, val[15:0], err[0], ok[0]);
    endtask : read_value
endmodule : mmr_host_model

// *** dv/tb.sv ***
`timescale 1ns/1ns
// self-checking bench for the motion monitor register bank
module tb;
    import mmr_pkg::*;
    logic              clk, srst, rd_en, rd_valid, rd_err, loop_active;
    logic              travel_tick, trip_clear, motor_running, op_start;
    logic [ADDR_W-1:0] rd_addr;
    logic [WORD_W-1:0] rd_data;
    logic [VAL_W-1:0]  loop_iter, cmd_pos, fb_pos, info_code, drv_temp;
    logic [VAL_W-1:0]  mot_temp, op_data_num, m_life, m_trip, m_h1, m_h2;
    logic [EVT_N-1:0]  evt, latch_clear;
    logic [VAL_W-1:0]  m_lat [8];
    logic [31:0]       v;
    logic [1:0]        e, k;
    integer            fails, num_checks, seed;

    mmr_bank u_mmr_bank (.clk(clk), .srst(srst), .rd_addr(rd_addr),
        .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_err(rd_err), .loop_active(loop_active), .loop_iter(loop_iter),
        .cmd_pos(cmd_pos), .fb_pos(fb_pos),
        .advance_event(evt[EVT_ADVANCE]), .low_branch_event(evt[EVT_LOW]),
        .high_branch_event(evt[EVT_HIGH]), .halt_event(evt[EVT_HALT]),
        .latch_clear(latch_clear), .info_code(info_code),
        .drv_temp(drv_temp), .mot_temp(mot_temp),
        .travel_tick(travel_tick), .trip_clear(trip_clear),
        .motor_running(motor_running), .op_start(op_start),
        .op_data_num(op_data_num));

    mmr_host_model u_mmr_host_model (.clk(clk), .rd_addr(rd_addr),
        .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_err(rd_err));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] exp_val(input int i);
        case (i)
            0:       return loop_active ? loop_iter : VAL_ZERO;
            9:       return info_code;
            10:      return drv_temp;
            11:      return mot_temp;
            12:      return m_life;
            13:      return m_trip;
            14:      return m_h1;
            15:      return m_h2;
            default: return m_lat[i-1];
        endcase
    endfunction : exp_val

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input int idx, input logic [35:0] x,
                       input logic [35:0] got);
        num_checks++;
        if (got !== x)
        begin
            fails++;
            $display("mismatch entry %0d exp %h got %h", idx, x, got);
        end
    endtask : chk

    task automatic check_all();
        for (int i = 0; i < NUM_ENTRIES; i++)
        begin
            u_mmr_host_model.read_value(REG_BASE + 16'(2 * i), v, e, k);
            chk(i, {2'b11, 2'b00, exp_val(i)}, {k, e, v});
        end
    endtask : check_all

    // live positions move right after the pulse so a late capture shows
    task automatic fire(input int n, input logic clr);
        @(negedge clk);
        cmd_pos = $random(seed);
        fb_pos = $random(seed);
        evt[n] = !clr;
        latch_clear[n] = clr;
        m_lat[2*n] = clr ? VAL_ZERO : cmd_pos;
        m_lat[2*n+1] = clr ? VAL_ZERO : fb_pos;
        @(negedge clk);
        evt = 4'h0;
        latch_clear = 4'h0;
        cmd_pos = ~cmd_pos;
        fb_pos = ~fb_pos;
    endtask : fire

    task automatic tick(input int n);
        repeat (n)
        begin
            @(negedge clk);
            travel_tick = 1'b1;
            @(negedge clk);
            travel_tick = 1'b0;
        end
        m_life += n;
        m_trip += n;
    endtask : tick

    task automatic start_op();
        @(negedge clk);
        op_start = 1'b1;
        op_data_num = $random(seed);
        m_h2 = m_h1;
        m_h1 = op_data_num;
        @(negedge clk);
        op_start = 1'b0;
    endtask : start_op

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial
    begin
        fails = 0;
        num_checks = 0;
        seed = 32'hB739;
        {srst, loop_active, travel_tick, trip_clear} = 4'hF - 4'h7;
        {motor_running, op_start, evt, latch_clear} = 10'h000;
        loop_iter = $random(seed);
        {cmd_pos, fb_pos, op_data_num} = {3{VAL_ZERO}};
        info_code = $random(seed);
        drv_temp = $random(seed);
        mot_temp = $random(seed);
        {m_life, m_trip} = {VAL_ZERO, VAL_ZERO};
        {m_h1, m_h2} = {VAL_NONE, VAL_NONE};
        for (int i = 0; i < 8; i++)
            m_lat[i] = VAL_ZERO;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        check_all();
        loop_active = 1'b1;
        check_all();
        loop_active = 1'b0;
        for (int n = 0; n < EVT_N; n++)
        begin
            fire(n, 1'b0);
            fire(n, 1'b0);
        end
        check_all();
        fire(EVT_HIGH, 1'b1);
        fire(EVT_ADVANCE, 1'b1);
        tick(1 + ($unsigned($random(seed)) % 8));
        check_all();
        @(negedge clk);
        trip_clear = 1'b1;
        m_trip = VAL_ZERO;
        @(negedge clk);
        trip_clear = 1'b0;
        tick(3);
        check_all();
        motor_running = 1'b1;
        loop_active = 1'b1;
        start_op();
        start_op();
        check_all();
        motor_running = 1'b0;
        loop_active = 1'b0;
        {m_h1, m_h2} = {VAL_NONE, VAL_NONE};
        repeat (2) @(negedge clk);
        check_all();
        u_mmr_host_model.read_value(16'h00E2, v, e, k);
        chk(16, {2'b11, 2'b11, VAL_ZERO}, {k, e, v});
        u_mmr_host_model.read_value(REG_END, v, e, k);
        chk(17, {2'b11, 2'b11, VAL_ZERO}, {k, e, v});
        complete_run();
    end
endmodule : tb

// *** rtl/mmr_bank.sv ***
`timescale 1ns/1ns
// read-only motion monitor register bank with event latches and meters
module mmr_bank
    import mmr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] rd_addr,
    input  wire logic              rd_en,
    output logic [WORD_W-1:0]      rd_data,
    output logic                   rd_valid,
    output logic                   rd_err,
    input  wire logic              loop_active,
    input  wire logic [VAL_W-1:0]  loop_iter,
    input  wire logic [VAL_W-1:0]  cmd_pos,
    input  wire logic [VAL_W-1:0]  fb_pos,
    input  wire logic              advance_event,
    input  wire logic              low_branch_event,
    input  wire logic              high_branch_event,
    input  wire logic              halt_event,
    input  wire logic [EVT_N-1:0]  latch_clear,
    input  wire logic [VAL_W-1:0]  info_code,
    input  wire logic [VAL_W-1:0]  drv_temp,
    input  wire logic [VAL_W-1:0]  mot_temp,
    input  wire logic              travel_tick,
    input  wire logic              trip_clear,
    input  wire logic              motor_running,
    input  wire logic              op_start,
    input  wire logic [VAL_W-1:0]  op_data_num
);
    mmr_latch_if lbus ();

    logic [VAL_W-1:0] cmd_lat [EVT_N];
    logic [VAL_W-1:0] fb_lat  [EVT_N];
    logic [EVT_N-1:0] event_vec;
    logic [VAL_W-1:0] loop_reg;
    logic [VAL_W-1:0] info_reg;
    logic [VAL_W-1:0] drv_reg;
    logic [VAL_W-1:0] mot_reg;
    logic [VAL_W-1:0] life_reg;
    logic [VAL_W-1:0] trip_reg;
    logic [VAL_W-1:0] cur_num;
    logic [VAL_W-1:0] prev_num;
    logic [VAL_W-1:0] hist1_val;
    logic [VAL_W-1:0] hist2_val;
    logic [VAL_W-1:0] sel_val;
    logic             in_range;
    logic             low_half;
    mmr_run_e         run_state;
    mmr_run_e         next_run_state;

    assign lbus.cmd_pos = cmd_pos;
    assign lbus.fb_pos  = fb_pos;
    assign lbus.srst    = srst;

    assign event_vec[EVT_ADVANCE] = advance_event;
    assign event_vec[EVT_LOW]     = low_branch_event;
    assign event_vec[EVT_HIGH]    = high_branch_event;
    assign event_vec[EVT_HALT]    = halt_event;

    genvar g;
    generate
        for (g = 0; g < EVT_N; g++)
        begin : g_lat
            mmr_event_latch u_lat (
                .clk         (clk),
                .bus         (lbus),
                .event_hit   (event_vec[g]),
                .clear       (latch_clear[g]),
                .cmd_latched (cmd_lat[g]),
                .fb_latched  (fb_lat[g])
            );
        end
    endgenerate

    // operation state; stopped has priority over loop reporting
    always_comb
    begin
        next_run_state = MMR_IDLE;
        if (motor_running && loop_active)
            next_run_state = MMR_LOOP;
        else if (motor_running)
            next_run_state = MMR_RUN;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            run_state <= MMR_IDLE;
        else
            run_state <= next_run_state;
    end

    // sampled monitor values so read data comes from flip-flops
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            loop_reg <= VAL_ZERO;
            info_reg <= VAL_ZERO;
            drv_reg  <= VAL_ZERO;
            mot_reg  <= VAL_ZERO;
        end
        else
        begin
            loop_reg <= loop_active ? loop_iter : VAL_ZERO;
            info_reg <= info_code;
            drv_reg  <= drv_temp;
            mot_reg  <= mot_temp;
        end
    end

    // lifetime meter has no clear path at all, only reset
    always_ff @(posedge clk)
    begin
        if (srst)
            life_reg <= VAL_ZERO;
        else if (travel_tick)
            life_reg <= life_reg + VAL_ONE;
    end

    // a tick in the clearing cycle counts as the first step after clear
    always_ff @(posedge clk)
    begin
        if (srst)
            trip_reg <= VAL_ZERO;
        else if (trip_clear)
            trip_reg <= travel_tick ? VAL_ONE : VAL_ZERO;
        else if (travel_tick)
            trip_reg <= trip_reg + VAL_ONE;
    end

    // history: shift the running number on each operation start while the motor runs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cur_num  <= VAL_NONE;
            prev_num <= VAL_NONE;
        end
        else if (!motor_running)
        begin
            cur_num  <= VAL_NONE;
            prev_num <= VAL_NONE;
        end
        else if (op_start)
        begin
            cur_num  <= op_data_num;
            prev_num <= cur_num;
        end
    end

    assign hist1_val = (run_state == MMR_IDLE) ? VAL_NONE : cur_num;
    assign hist2_val = (run_state == MMR_IDLE) ? VAL_NONE : prev_num;

    // the select below drops bit 0, so both halves share one entry
    assign in_range  = (rd_addr >= REG_BASE) && (rd_addr < REG_END);
    assign low_half  = rd_addr[0];

    always_comb
    begin
        sel_val = VAL_ZERO;
        case ({rd_addr[ADDR_W-1:1], 1'b0})
            REG_LOOP:     sel_val = loop_reg;
            REG_ADV_CMD:  sel_val = cmd_lat[EVT_ADVANCE];
            REG_ADV_FB:   sel_val = fb_lat[EVT_ADVANCE];
            REG_LOW_CMD:  sel_val = cmd_lat[EVT_LOW];
            REG_LOW_FB:   sel_val = fb_lat[EVT_LOW];
            REG_HIGH_CMD: sel_val = cmd_lat[EVT_HIGH];
            REG_HIGH_FB:  sel_val = fb_lat[EVT_HIGH];
            REG_HALT_CMD: sel_val = cmd_lat[EVT_HALT];
            REG_HALT_FB:  sel_val = fb_lat[EVT_HALT];
            REG_INFO:     sel_val = info_reg;
            REG_DRV_TEMP: sel_val = drv_reg;
            REG_MOT_TEMP: sel_val = mot_reg;
            REG_LIFE:     sel_val = life_reg;
            REG_TRIP:     sel_val = trip_reg;
            REG_HIST1:    sel_val = hist1_val;
            REG_HIST2:    sel_val = hist2_val;
            default:      sel_val = VAL_ZERO;
        endcase
    end

    // one-cycle read answer; unmapped addresses flag an error and read zero
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_data  <= WORD_ZERO;
            rd_valid <= 1'b0;
            rd_err   <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            rd_err   <= rd_en && !in_range;
            if (rd_en)
                rd_data <= !in_range ? WORD_ZERO
                         : low_half ? sel_val[WORD_W-1:0]
                         : sel_val[VAL_W-1:WORD_W];
        end
    end

    // the read request as taken on a rising edge, per half and mapping
    sequence s_read_upper;
        rd_en && in_range && !low_half;
    endsequence

    sequence s_read_lower;
        rd_en && in_range && low_half;
    endsequence

    sequence s_read_unmapped;
        rd_en && !in_range;
    endsequence

    // two stopped cycles, so the registered run state has caught up
    sequence s_stopped_two;
        !motor_running ##1 !motor_running;
    endsequence

    // an operation starts and the motor still runs one cycle later
    sequence s_op_started;
        motor_running && op_start ##1 motor_running;
    endsequence

    AST_READ_UPPER: assert property (@(posedge clk) disable iff (srst)
        s_read_upper |=> rd_valid && !rd_err
                      && rd_data == $past(sel_val[VAL_W-1:WORD_W]))
        else $error("upper half read mismatch");
    AST_READ_LOWER: assert property (@(posedge clk) disable iff (srst)
        s_read_lower |=> rd_valid && !rd_err
                      && rd_data == $past(sel_val[WORD_W-1:0]))
        else $error("lower half read mismatch");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (srst)
        s_read_unmapped |=> rd_valid && rd_err && rd_data == WORD_ZERO)
        else $error("unmapped read not flagged");
    AST_NO_READ: assert property (@(posedge clk) disable iff (srst)
        !rd_en |=> !rd_valid && !rd_err)
        else $error("read answer without a request");

    AST_LOOP_ZERO: assert property (@(posedge clk) disable iff (srst)
        !loop_active |=> loop_reg == VAL_ZERO)
        else $error("loop count not zero outside loop");
    AST_LOOP_COUNT: assert property (@(posedge clk) disable iff (srst)
        loop_active |=> loop_reg == $past(loop_iter))
        else $error("loop count does not follow iteration");
    AST_RUN_LOOP: assert property (@(posedge clk) disable iff (srst)
        motor_running && loop_active |=> run_state == MMR_LOOP)
        else $error("run state missed loop operation");

    // event routing: each pulse must land in its own latch pair
    AST_ADV_CAP: assert property (@(posedge clk) disable iff (srst)
        advance_event |=> cmd_lat[EVT_ADVANCE] == $past(cmd_pos)
                       && fb_lat[EVT_ADVANCE] == $past(fb_pos))
        else $error("advance event capture wrong");
    AST_LOW_CAP: assert property (@(posedge clk) disable iff (srst)
        low_branch_event |=> cmd_lat[EVT_LOW] == $past(cmd_pos)
                          && fb_lat[EVT_LOW] == $past(fb_pos))
        else $error("low branch capture wrong");
    AST_HIGH_CAP: assert property (@(posedge clk) disable iff (srst)
        high_branch_event |=> cmd_lat[EVT_HIGH] == $past(cmd_pos)
                           && fb_lat[EVT_HIGH] == $past(fb_pos))
        else $error("high branch capture wrong");
    AST_HALT_CAP: assert property (@(posedge clk) disable iff (srst)
        halt_event |=> cmd_lat[EVT_HALT] == $past(cmd_pos)
                    && fb_lat[EVT_HALT] == $past(fb_pos))
        else $error("halt capture wrong");

    AST_HIST_STOP: assert property (@(posedge clk) disable iff (srst)
        s_stopped_two |-> hist1_val == VAL_NONE && hist2_val == VAL_NONE)
        else $error("history not minus one while stopped");
    AST_HIST_CUR: assert property (@(posedge clk) disable iff (srst)
        s_op_started |-> hist1_val == $past(op_data_num))
        else $error("first history not the current number");
    AST_HIST_SHIFT: assert property (@(posedge clk) disable iff (srst)
        s_op_started |-> hist2_val == $past(hist1_val))
        else $error("second history not the previous number");

    AST_LIFE_STEP: assert property (@(posedge clk) disable iff (srst)
        travel_tick |=> life_reg == $past(life_reg) + VAL_ONE)
        else $error("lifetime travel did not step");
    AST_LIFE_HOLD: assert property (@(posedge clk) disable iff (srst)
        !travel_tick |=> $stable(life_reg))
        else $error("lifetime travel changed without travel");
    AST_TRIP_CLR: assert property (@(posedge clk) disable iff (srst)
        trip_clear && !travel_tick |=> trip_reg == VAL_ZERO)
        else $error("trip meter not cleared");
    AST_TRIP_BOTH: assert property (@(posedge clk) disable iff (srst)
        trip_clear && travel_tick |=> trip_reg == VAL_ONE)
        else $error("trip clear with tick not one");
    AST_TRIP_STEP: assert property (@(posedge clk) disable iff (srst)
        !trip_clear && travel_tick |=> trip_reg == $past(trip_reg) + VAL_ONE)
        else $error("trip meter did not step");
    AST_TRIP_HOLD: assert property (@(posedge clk) disable iff (srst)
        !trip_clear && !travel_tick |=> $stable(trip_reg))
        else $error("trip meter changed without cause");

    AST_INFO: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> info_reg == $past(info_code))
        else $error("information code not tracked");
    AST_DRV_TEMP: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> drv_reg == $past(drv_temp))
        else $error("driver temperature not tracked");
    AST_MOT_TEMP: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> mot_reg == $past(mot_temp))
        else $error("motor temperature not tracked");
endmodule : mmr_bank

// *** rtl/mmr_event_latch.sv ***
`timescale 1ns/1ns
// one event latch pair: command and feedback position
module mmr_event_latch
    import mmr_pkg::*;
(
    input  wire logic             clk,
    mmr_latch_if.latch            bus,
    input  wire logic             event_hit,
    input  wire logic             clear,
    output logic [VAL_W-1:0]      cmd_latched,
    output logic [VAL_W-1:0]      fb_latched
);
    // the event wins over a clear in the same cycle so no capture is lost
    always_ff @(posedge clk)
    begin
        if (bus.srst)
        begin
            cmd_latched <= VAL_ZERO;
            fb_latched  <= VAL_ZERO;
        end
        else if (event_hit)
        begin
            cmd_latched <= bus.cmd_pos;
            fb_latched  <= bus.fb_pos;
        end
        else if (clear)
        begin
            cmd_latched <= VAL_ZERO;
            fb_latched  <= VAL_ZERO;
        end
    end

    AST_CAPTURE: assert property (@(posedge clk) disable iff (bus.srst)
        event_hit |=> cmd_latched == $past(bus.cmd_pos)
                  && fb_latched == $past(bus.fb_pos))
        else $error("latch did not capture positions");
    AST_CLEAR: assert property (@(posedge clk) disable iff (bus.srst)
        clear && !event_hit |=> cmd_latched == VAL_ZERO
                             && fb_latched == VAL_ZERO)
        else $error("cleared latch not zero");
    AST_HOLD: assert property (@(posedge clk) disable iff (bus.srst)
        !event_hit && !clear |=> $stable(cmd_latched) && $stable(fb_latched))
        else $error("latch changed without cause");
endmodule : mmr_event_latch

// *** rtl/mmr_latch_if.sv ***
`timescale 1ns/1ns
// shared capture signals between the bank and its event latches
interface mmr_latch_if;
    import mmr_pkg::*;
    logic [VAL_W-1:0] cmd_pos;
    logic [VAL_W-1:0] fb_pos;
    logic             srst;
    modport bank  (output cmd_pos, output fb_pos, output srst);
    modport latch (input cmd_pos, input fb_pos, input srst);
endinterface : mmr_latch_if

// *** rtl/mmr_pkg.sv ***
// constants shared by the motion monitor register bank
package mmr_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          WORD_W        = 16;
    localparam int          VAL_W         = 32;
    localparam int          NUM_ENTRIES   = 16;
    localparam int          IDX_W         = 4;
    localparam int          EVT_N         = 4;
    localparam int          EVT_ADVANCE   = 0;
    localparam int          EVT_LOW       = 1;
    localparam int          EVT_HIGH      = 2;
    localparam int          EVT_HALT      = 3;
    localparam int          SEQ_W         = 2;
    localparam logic [15:0] REG_BASE      = 16'h00E4;
    localparam logic [15:0] REG_LOOP      = 16'h00E4;
    localparam logic [15:0] REG_ADV_CMD   = 16'h00E6;
    localparam logic [15:0] REG_ADV_FB    = 16'h00E8;
    localparam logic [15:0] REG_LOW_CMD   = 16'h00EA;
    localparam logic [15:0] REG_LOW_FB    = 16'h00EC;
    localparam logic [15:0] REG_HIGH_CMD  = 16'h00EE;
    localparam logic [15:0] REG_HIGH_FB   = 16'h00F0;
    localparam logic [15:0] REG_HALT_CMD  = 16'h00F2;
    localparam logic [15:0] REG_HALT_FB   = 16'h00F4;
    localparam logic [15:0] REG_INFO      = 16'h00F6;
    localparam logic [15:0] REG_DRV_TEMP  = 16'h00F8;
    localparam logic [15:0] REG_MOT_TEMP  = 16'h00FA;
    localparam logic [15:0] REG_LIFE      = 16'h00FC;
    localparam logic [15:0] REG_TRIP      = 16'h00FE;
    localparam logic [15:0] REG_HIST1     = 16'h0100;
    localparam logic [15:0] REG_HIST2     = 16'h0102;
    localparam logic [15:0] REG_END       = 16'h0104;
    localparam logic [31:0] VAL_ZERO      = 32'h0000_0000;
    localparam logic [31:0] VAL_NONE      = 32'hFFFF_FFFF;
    localparam logic [31:0] VAL_ONE       = 32'h0000_0001;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;
    typedef enum logic [1:0] {
        MMR_IDLE = 2'b00,
        MMR_RUN  = 2'b01,
        MMR_LOOP = 2'b11
    } mmr_run_e;
endpackage : mmr_pkg
